// [scfl_pkg.sv]
// Constants, encodings and timing for the serial flash configuration loader.
// Assumes a 40 MHz core clock and a separate internal oscillator clock for the link.
package scfl_pkg;
   // ==========================================================================
   // Mode and variant codes
   localparam logic [2:0] MODE_SERIAL = 3'h0;
   localparam logic [2:0] MODE_SPI = 3'h1;
   localparam logic [2:0] VS_FAST = 3'h7;
   localparam logic [2:0] VS_READ = 3'h5;
   localparam logic [2:0] VS_ARRAY = 3'h6;
   localparam logic [7:0] OPC_FAST = 8'h0B;
   localparam logic [7:0] OPC_READ = 8'h03;
   localparam logic [7:0] OPC_ARRAY = 8'hE8;
   localparam logic [2:0] DUMMY_FAST = 3'h1;
   localparam logic [2:0] DUMMY_READ = 3'h0;
   localparam logic [2:0] DUMMY_ARRAY = 3'h4;
   // ==========================================================================
   // Header layout: opcode, 24-bit zero address, up to four dummy bytes
   localparam int HDR_W = 64;
   localparam logic [23:0] START_ADDR = 24'h00_0000;
   localparam logic [31:0] DUMMY_FILL = 32'h0000_0000;
   localparam logic [6:0] HDR_BASE_BITS = 7'h20;
   localparam int DUMMY_SHIFT = 3;
   // ==========================================================================
   // Check sequence
   localparam logic [15:0] CRC_POLY = 16'h1021;
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam int CRC_W = 16;
   // ==========================================================================
   // Timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int PROG_MIN_NS = 500;
   localparam int PROG_MIN_CYC = (PROG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // ==========================================================================
   // Core sequencer states
   typedef enum logic [4:0] {
      C_CLEAR = 5'h01,
      C_SAMPLE = 5'h02,
      C_LOAD = 5'h04,
      C_DONE = 5'h08,
      C_ERR = 5'h10
   } scfl_core_e;
   // Link states
   typedef enum logic [3:0] {
      L_IDLE = 4'h1,
      L_HEAD = 4'h2,
      L_DATA = 4'h4,
      L_FIN = 4'h8
   } scfl_link_e;
endpackage : scfl_pkg

// [scfl_sync.sv]
// Two-stage synchroniser for levels entering a clock domain.
// Assumes each bit is a slow level; multi-bit values must be stable while sampled.
module scfl_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;
   // First stage feeds only the second stage
   always_ff @(posedge clk) begin
      meta_q <= d;
      q <= meta_q;
   end
endmodule : scfl_sync

// [scfl_loader.sv]
// Configuration loader: sequencer on core_clk, serial and SPI link on osc_clk.
// Assumes open-drain pins are resolved outside and pulled high; osc_clk runs free.
module scfl_loader #(
   parameter int CLEAR_CYCLES = 64,
   parameter int CFG_BITS = 1024
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic osc_clk,
   input wire logic program_request_n,
   input wire logic [2:0] mode_select,
   input wire logic [2:0] flash_variant_select,
   input wire logic init_i,
   output logic init_o,
   output logic init_oe,
   input wire logic done_i,
   output logic done_o,
   output logic done_oe,
   output logic mode_pins_user,
   output logic cfg_clk,
   output logic flash_cs_n,
   output logic flash_mosi,
   input wire logic cfg_din,
   output logic cfg_bit,
   output logic cfg_bit_valid
);
   // ==========================================================================
   // Core domain
   scfl_pkg::scfl_core_e st_q;
   logic [8:0] pin_s;
   logic prog_s, init_s, done_s, fin_s, ok_s;
   logic [2:0] mode_s, vs_s, mode_q, vs_q;
   logic [7:0] prog_cnt_q;
   logic prog_armed_q, restart, run_q, mode_ok;
   logic [15:0] clr_cnt_q;

   // Pins into the core domain
   scfl_sync #(.W(9)) u_pin_sync (.clk(core_clk),
      .d({program_request_n, init_i, done_i, mode_select, flash_variant_select}), .q(pin_s));
   assign {prog_s, init_s, done_s, mode_s, vs_s} = pin_s;

   // Program request must stay low for the minimum time before release restarts
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         prog_cnt_q <= 8'h00;
         prog_armed_q <= 1'b0;
      end else if (!prog_s) begin
         if (prog_cnt_q < 8'(scfl_pkg::PROG_MIN_CYC)) prog_cnt_q <= prog_cnt_q + 8'h01;
         if (prog_cnt_q >= 8'(scfl_pkg::PROG_MIN_CYC - 1)) prog_armed_q <= 1'b1;
      end else begin
         prog_cnt_q <= 8'h00;
         prog_armed_q <= 1'b0;
      end
   end
   assign restart = prog_armed_q && prog_s;

   // Mode legal, and variant legal when SPI is chosen
   assign mode_ok = (mode_s == scfl_pkg::MODE_SERIAL) || ((mode_s == scfl_pkg::MODE_SPI) &&
      (vs_s == scfl_pkg::VS_FAST || vs_s == scfl_pkg::VS_READ || vs_s == scfl_pkg::VS_ARRAY));

   // Sequencer
   always_ff @(posedge core_clk) begin
      if (!nrst || restart) begin
         st_q <= scfl_pkg::C_CLEAR;
      end else begin
         unique case (st_q)
            scfl_pkg::C_CLEAR: begin
               if (prog_s && clr_cnt_q == 16'(CLEAR_CYCLES - 1)) st_q <= scfl_pkg::C_SAMPLE;
            end
            scfl_pkg::C_SAMPLE: begin
               // Sample once the released indicator reads high
               if (init_s) st_q <= mode_ok ? scfl_pkg::C_LOAD : scfl_pkg::C_ERR;
            end
            scfl_pkg::C_LOAD: begin
               if (fin_s) st_q <= ok_s ? scfl_pkg::C_DONE : scfl_pkg::C_ERR;
            end
            scfl_pkg::C_DONE: st_q <= scfl_pkg::C_DONE;
            scfl_pkg::C_ERR: st_q <= scfl_pkg::C_ERR;
         endcase
      end
   end

   // Clearing time counter, started afresh by every accepted program request
   always_ff @(posedge core_clk) begin
      if (!nrst || restart || st_q != scfl_pkg::C_CLEAR) clr_cnt_q <= 16'h0000;
      else if (prog_s) clr_cnt_q <= clr_cnt_q + 16'h0001;
   end

   // Mode and variant captured at sampling; run level to the link
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         mode_q <= scfl_pkg::MODE_SERIAL;
         vs_q <= scfl_pkg::VS_FAST;
         run_q <= 1'b0;
      end else begin
         if (st_q == scfl_pkg::C_SAMPLE && init_s) begin
            mode_q <= mode_s;
            vs_q <= vs_s;
         end
         run_q <= (st_q == scfl_pkg::C_LOAD) && !fin_s && !restart;
      end
   end

   // Open-drain pins drive low only
   assign init_o = 1'b0;
   assign done_o = 1'b0;
   assign init_oe = (st_q == scfl_pkg::C_CLEAR) || (st_q == scfl_pkg::C_ERR);
   assign done_oe = (st_q != scfl_pkg::C_DONE);
   assign mode_pins_user = (st_q == scfl_pkg::C_DONE) && done_s;

   // ==========================================================================
   // Link domain
   scfl_pkg::scfl_link_e lst_q;
   logic [5:0] lin_s;
   logic lrst_n, run_s, lmode_spi;
   logic [2:0] lvs_s;
   logic [scfl_pkg::HDR_W-1:0] hdr_q;
   logic [6:0] hcnt_q, hlen_q;
   logic [15:0] bcnt_q, crc_q, rx_q;
   logic fin_q, lok_q, cclk_q, cs_n_q, bit_q, bitv_q, rise;
   logic [7:0] opc;
   logic [2:0] dum;
   logic [1:0] back_s;

   scfl_sync #(.W(6)) u_link_sync (.clk(osc_clk),
      .d({nrst, run_q, mode_q == scfl_pkg::MODE_SPI, vs_q}), .q(lin_s));
   assign {lrst_n, run_s, lmode_spi, lvs_s} = lin_s;
   scfl_sync #(.W(2)) u_back_sync (.clk(core_clk), .d({fin_q, lok_q}), .q(back_s));
   assign {fin_s, ok_s} = back_s;

   // Variant decode of opcode and dummy bytes
   always_comb begin
      opc = scfl_pkg::OPC_FAST;
      dum = scfl_pkg::DUMMY_FAST;
      if (lvs_s == scfl_pkg::VS_READ) begin
         opc = scfl_pkg::OPC_READ;
         dum = scfl_pkg::DUMMY_READ;
      end else if (lvs_s == scfl_pkg::VS_ARRAY) begin
         opc = scfl_pkg::OPC_ARRAY;
         dum = scfl_pkg::DUMMY_ARRAY;
      end
   end
   assign rise = !cclk_q;

   // Link sequencer, clock generation and header shifting
   always_ff @(posedge osc_clk) begin
      if (!lrst_n || !run_s) begin
         lst_q <= scfl_pkg::L_IDLE;
         cclk_q <= 1'b0;
         cs_n_q <= 1'b1;
         fin_q <= 1'b0;
         lok_q <= 1'b0;
         hdr_q <= '0;
         hcnt_q <= 7'h00;
         hlen_q <= 7'h00;
      end else begin
         unique case (lst_q)
            scfl_pkg::L_IDLE: begin
               if (!fin_q) begin
                  hdr_q <= {opc, scfl_pkg::START_ADDR, scfl_pkg::DUMMY_FILL};
                  hlen_q <= scfl_pkg::HDR_BASE_BITS + 7'({dum, 3'h0});
                  hcnt_q <= 7'h00;
                  cs_n_q <= !lmode_spi;
                  lst_q <= lmode_spi ? scfl_pkg::L_HEAD : scfl_pkg::L_DATA;
               end
            end
            scfl_pkg::L_HEAD: begin
               cclk_q <= ~cclk_q;
               if (cclk_q) begin
                  hdr_q <= {hdr_q[scfl_pkg::HDR_W-2:0], 1'b0};
                  hcnt_q <= hcnt_q + 7'h01;
                  if (hcnt_q == hlen_q - 7'h01) lst_q <= scfl_pkg::L_DATA;
               end
            end
            scfl_pkg::L_DATA: begin
               cclk_q <= ~cclk_q;
               if (rise && bcnt_q == 16'(CFG_BITS - 1)) begin
                  lok_q <= ({rx_q[14:0], cfg_din} == crc_q);
                  lst_q <= scfl_pkg::L_FIN;
               end
            end
            scfl_pkg::L_FIN: begin
               cclk_q <= 1'b0;
               cs_n_q <= 1'b1;
               fin_q <= 1'b1;
            end
         endcase
      end
   end

   // Data capture on each rising clock edge, check sequence over the payload
   always_ff @(posedge osc_clk) begin
      if (!lrst_n || lst_q != scfl_pkg::L_DATA) begin
         bcnt_q <= 16'h0000;
         crc_q <= scfl_pkg::CRC_INIT;
         rx_q <= 16'h0000;
         bitv_q <= 1'b0;
         bit_q <= 1'b0;
      end else begin
         bitv_q <= rise;
         if (rise) begin
            bit_q <= cfg_din;
            bcnt_q <= bcnt_q + 16'h0001;
            rx_q <= {rx_q[14:0], cfg_din};
            if (bcnt_q < 16'(CFG_BITS - scfl_pkg::CRC_W)) begin
               crc_q <= {crc_q[14:0], 1'b0} ^
                  ((crc_q[15] ^ cfg_din) ? scfl_pkg::CRC_POLY : 16'h0000);
            end
         end
      end
   end

   assign cfg_clk = cclk_q;
   assign flash_cs_n = cs_n_q;
   assign flash_mosi = hdr_q[scfl_pkg::HDR_W-1];
   assign cfg_bit = bit_q;
   assign cfg_bit_valid = bitv_q;

   // ==========================================================================
   // Checks on the core side
   clear_init_low_a: assert property (@(posedge core_clk) disable iff (!nrst)
      $rose(st_q == scfl_pkg::C_SAMPLE) |-> $past(init_oe) &&
      $past(clr_cnt_q) == 16'(CLEAR_CYCLES - 1)) else $error("sampled before clearing ended");
   prog_restart_a: assert property (@(posedge core_clk) disable iff (!nrst)
      restart |=> st_q == scfl_pkg::C_CLEAR && init_oe && done_oe)
      else $error("restart did not clear");
   prog_short_a: assert property (@(posedge core_clk) disable iff (!nrst)
      $rose(prog_s) && $past(prog_cnt_q) < 8'(scfl_pkg::PROG_MIN_CYC - 1) |-> !restart)
      else $error("short program pulse restarted");
   done_cause_a: assert property (@(posedge core_clk) disable iff (!nrst)
      $fell(done_oe) |-> $past(st_q == scfl_pkg::C_LOAD && fin_s && ok_s))
      else $error("done rose without success");
   crc_error_a: assert property (@(posedge core_clk) disable iff (!nrst)
      st_q == scfl_pkg::C_LOAD && fin_s && !ok_s && !restart |=> init_oe [*2])
      else $error("check error did not pull indicator");
   user_release_a: assert property (@(posedge core_clk) disable iff (!nrst)
      mode_pins_user |-> !done_oe && $past(!done_oe, 2)) else $error("mode pins released early");
   sample_wait_a: assert property (@(posedge core_clk) disable iff (!nrst)
      st_q == scfl_pkg::C_SAMPLE && !init_s && !restart |=> st_q == scfl_pkg::C_SAMPLE)
      else $error("sampled with indicator low");
   // Checks on the link side
   idle_quiet_a: assert property (@(posedge osc_clk) disable iff (!lrst_n)
      lst_q == scfl_pkg::L_IDLE |-> !cclk_q && cs_n_q) else $error("link not idle");
   serial_desel_a: assert property (@(posedge osc_clk) disable iff (!lrst_n)
      lst_q != scfl_pkg::L_IDLE && !lmode_spi |-> cs_n_q) else $error("flash selected");
   head_select_a: assert property (@(posedge osc_clk) disable iff (!lrst_n)
      lst_q == scfl_pkg::L_HEAD && run_s |=> !cs_n_q) else $error("header not selected");
   cover_done_c: cover property (@(posedge core_clk) disable iff (!nrst) $fell(done_oe));
   cover_crc_c: cover property (@(posedge core_clk) disable iff (!nrst)
      st_q == scfl_pkg::C_LOAD && fin_s && !ok_s);
   cover_restart_c: cover property (@(posedge core_clk) disable iff (!nrst)
      st_q == scfl_pkg::C_LOAD && restart);
   cover_spi_c: cover property (@(posedge osc_clk) disable iff (!lrst_n)
      lst_q == scfl_pkg::L_HEAD ##1 lst_q == scfl_pkg::L_DATA);
endmodule : scfl_loader

// [scfl_flash_model.sv]
// Behavioural configuration memory at the far side of the loader, serial or SPI.
// Assumes cfg_clk is a register of osc_clk; rewind is held for some osc_clk edges.
module scfl_flash_model #(
   parameter int N = 64
) (
   input wire logic osc_clk,
   input wire logic serial_mode,
   input wire logic rewind,
   input wire logic [N-1:0] data,
   input wire logic cfg_clk,
   input wire logic flash_cs_n,
   input wire logic flash_mosi,
   output logic cfg_din,
   output logic [63:0] hdr,
   output logic [7:0] hdr_len
);
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_prev, take;
   logic [7:0] want, hdr_next;
   int idx;
   // Dummy bytes that each read command expects
   function automatic logic [7:0] dummies(input logic [7:0] op);
      return (op == 8'h0B) ? 8'h01 : ((op == 8'hE8) ? 8'h04 : 8'h00);
   endfunction : dummies
   // ==========================================================================
   // Edge-driven shift logic
   // The clock is a register of osc_clk: a high level seen here falls at this very edge
   assign take = !flash_cs_n && cfg_clk && !clk_prev && hdr_len < want;
   assign hdr_next = hdr_len + {7'h00, take};
   always @(posedge osc_clk) begin
      clk_prev <= cfg_clk;
      if (rewind) begin
         hdr <= '0;
         hdr_len <= '0;
         want <= 8'hFF;
         idx <= serial_mode ? 1 : 0;
         cfg_din <= data[N-1];
      end else begin
         if (take) begin
            hdr <= {hdr[62:0], flash_mosi};
            hdr_len <= hdr_next;
         end
         if (hdr_len == 8'h08 && want == 8'hFF) begin
            want <= 8'h20 + 8'h08 * dummies(hdr[7:0]);
         end
         if (!serial_mode && flash_cs_n) begin
            cfg_din <= ~cfg_din; // Deselected: no stale value
         end else if (cfg_clk) begin
            // Next bit leaves on the falling edge, so it stands at the following rise
            if (idx < N && (serial_mode || hdr_next == want)) begin
               cfg_din <= data[N-1-idx];
               idx <= idx + 1;
            end else begin
               cfg_din <= ~cfg_din;
            end
         end
      end
   end
endmodule : scfl_flash_model

// [serial_flash_config_loader_bench.sv]
// Self-checking bench for the loader with a memory model on the link.
// Assumes open-drain init and done pins pulled high outside the loader.
module serial_flash_config_loader_bench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int NB = 64;
   logic core_clk, osc_clk, nrst, prog_n, init_oe, done_oe, user, cfg_clk, cs_n, mosi, din;
   logic cfg_bit, bit_valid, serial, rewind, init_lo, done_lo;
   logic [2:0] mode, vs;
   logic [NB-1:0] data, got;
   logic [63:0] hdr;
   logic [7:0] hdr_len;
   int bad_count, checks, seed;
   scfl_loader #(.CLEAR_CYCLES(8), .CFG_BITS(NB)) dut_u (.core_clk(core_clk), .nrst(nrst),
      .osc_clk(osc_clk), .program_request_n(prog_n), .mode_select(mode),
      .flash_variant_select(vs), .init_i(!init_oe), .init_o(init_lo), .init_oe(init_oe),
      .done_i(!done_oe), .done_o(done_lo), .done_oe(done_oe), .mode_pins_user(user),
      .cfg_clk(cfg_clk), .flash_cs_n(cs_n), .flash_mosi(mosi), .cfg_din(din),
      .cfg_bit(cfg_bit), .cfg_bit_valid(bit_valid));
   scfl_flash_model #(.N(NB)) mem_u (.osc_clk(osc_clk), .serial_mode(serial), .rewind(rewind),
      .data(data), .cfg_clk(cfg_clk), .flash_cs_n(cs_n), .flash_mosi(mosi), .cfg_din(din),
      .hdr(hdr), .hdr_len(hdr_len));
   // ==========================================================================
   // Clocks and collection of captured bits
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   initial begin
      osc_clk = 1'b0;
      #7;
      forever #32 osc_clk = ~osc_clk;
   end
   always @(posedge osc_clk) begin
      if (rewind) got <= '0;
      else if (bit_valid === 1'b1) got <= {got[NB-2:0], cfg_bit};
   end
   // ==========================================================================
   // Helpers
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
         bad_count++;
      end
   endtask : check
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : end_of_test
   function automatic logic [NB-1:0] with_crc(input logic [NB-17:0] p);
      logic [15:0] c;
      c = scfl_pkg::CRC_INIT;
      for (int i = NB - 17; i >= 0; i--) begin
         c = {c[14:0], 1'b0} ^ ((c[15] ^ p[i]) ? scfl_pkg::CRC_POLY : 16'h0000);
      end
      return {p, c};
   endfunction : with_crc
   // Program pulse of a given length with new mode and variant pins
   task automatic restart(input logic [2:0] m, input logic [2:0] v, input int low);
      @(posedge core_clk);
      prog_n <= 1'b0;
      mode <= m;
      vs <= v;
      serial <= (m == scfl_pkg::MODE_SERIAL);
      rewind <= 1'b1;
      repeat (low) @(posedge core_clk);
      prog_n <= 1'b1;
      rewind <= 1'b0;
      repeat (6) @(posedge core_clk);
      check(init_oe, 1'b1);
      check({init_lo, done_lo}, 2'h0);
   endtask : restart
   // Full load; ok low corrupts the check value
   task automatic run_load(input logic [2:0] m, input logic [2:0] v, input logic [7:0] opc,
                           input int d, input logic ok);
      int n;
      data <= with_crc(48'({$random(seed), $random(seed)})) ^ {{(NB-1){1'b0}}, !ok};
      restart(m, v, 25);
      for (n = 0; n < 100 && init_oe !== 1'b0; n++) @(posedge core_clk);
      check({cfg_clk, cs_n, done_oe}, 3'h3);
      for (n = 0; n < 4000 && done_oe !== 1'b0 && init_oe !== 1'b1; n++) @(posedge core_clk);
      repeat (6) @(posedge core_clk);
      check({done_oe, init_oe}, {!ok, !ok});
      check(user, ok);
      if (ok) check(got, data);
      if (m == scfl_pkg::MODE_SPI) begin
         check(hdr_len, 32 + 8 * d);
         check(hdr, 64'(opc) << (24 + 8 * d));
      end else begin
         check(hdr_len, 8'h00);
      end
      $display("test done: mode %h variant %h ok %h", m, v, ok);
   endtask : run_load
   // ==========================================================================
   // Main sequence and watchdog
   initial begin
      logic [2:0] vt [3];
      logic [7:0] ot [3];
      int dt [3];
      vt = '{3'h7, 3'h5, 3'h6};
      ot = '{8'h0B, 8'h03, 8'hE8};
      dt = '{1, 0, 4};
      seed = 25;
      bad_count = 0;
      checks = 0;
      nrst = 1'b0;
      prog_n = 1'b1;
      mode = scfl_pkg::MODE_SERIAL;
      vs = 3'h0;
      serial = 1'b1;
      rewind = 1'b1;
      data = '0;
      repeat (10) @(posedge core_clk);
      nrst <= 1'b1;
      run_load(scfl_pkg::MODE_SERIAL, 3'h0, 8'h00, 0, 1'b1);
      for (int k = 0; k < 3; k++) run_load(scfl_pkg::MODE_SPI, vt[k], ot[k], dt[k], 1'b1);
      run_load(scfl_pkg::MODE_SPI, 3'h7, 8'h0B, 1, 1'b0);
      // Reserved variant is refused and no flash access starts
      restart(scfl_pkg::MODE_SPI, 3'h4, 25);
      repeat (30) @(posedge core_clk);
      check({init_oe, cs_n, done_oe}, 3'h7);
      $display("test done: reserved variant");
      // Short program pulse leaves the error state untouched
      restart(scfl_pkg::MODE_SERIAL, 3'h0, 10);
      repeat (30) @(posedge core_clk);
      check(init_oe, 1'b1);
      $display("test done: short program pulse");
      end_of_test();
   end
   initial begin
      #1_000_000;
      bad_count++;
      end_of_test();
   end
endmodule : serial_flash_config_loader_bench
